// [hdl/bbs_cfg.svh]
// constants for the battery-backup supervisor logic
// assumes a 100 MHz clk; times are in their printed units
`ifndef BBS_CFG_SVH
`define BBS_CFG_SVH
`define BBS_CLK_MHZ        100
`define BBS_SAMPLE_MS      200
`define BBS_MEAS_US        25
`define BBS_CE_HOLD_US     15
`define BBS_POR_MS         100
`define BBS_SAMPLE_CYC     (`BBS_SAMPLE_MS * 1000 * `BBS_CLK_MHZ)
`define BBS_MEAS_CYC       (`BBS_MEAS_US * `BBS_CLK_MHZ)
`define BBS_CE_HOLD_CYC    (`BBS_CE_HOLD_US * `BBS_CLK_MHZ)
`define BBS_POR_CYC        (`BBS_POR_MS * 1000 * `BBS_CLK_MHZ)
`define BBS_CNT_W          32
// synchroniser reset image: inputs at their idle levels, so no false
// switchover or chip-select edge follows reset release
`define BBS_SYNC_IDLE      10'h0d5
`endif

// [hdl/bbs_pkg.sv]
// types for the battery-backup supervisor logic
// assumes bbs_cfg.svh is included alongside
package bbs_pkg;
    typedef enum logic [1:0] {
        BBS_CE_PASS  = 2'b00,
        BBS_CE_DRAIN = 2'b01,
        BBS_CE_BLOCK = 2'b11
    } bbs_ce_t;
endpackage : bbs_pkg

// [hdl/bbs_supervisor.sv]
// supervisor control: source select, seal, battery check, chip-select gate
// assumes comparator flags arrive asynchronous; clk 100 MHz, rst_n async low
//
// Overview of operation
// - seal keeps battery isolated from circuitry
// - seal released on reset output rising edge
// - sample battery every 200 ms, 25 us
// - measurement runs only after reset release
// - low battery sample drives good output low
// - reset off: chip select passes through
// - reset on: chip select path blocked
// - input high at reset: block at once
// - input low: block on rise or 15 us
// - blocked path pulls output to switched supply
// - aux output low below reference
// - aux output high above reference plus hysteresis
// - low-line warning follows 2% threshold
// - on-battery output high when battery feeds
// - battery when forced, or below threshold and above main
// - return to main on either recovery
// - reset held low, released after delay
// - force input latches backup mode
`timescale 1ns/10ps
`include "bbs_cfg.svh"

module bbs_supervisor
    import bbs_pkg::*;
#(
    parameter logic [31:0] SAMPLE_CYC = `BBS_SAMPLE_CYC,
    parameter logic [31:0] POR_CYC    = `BBS_POR_CYC
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic above_reset_thr,
    input  wire logic above_lowline_thr,
    input  wire logic main_above_batt,
    input  wire logic batt_above_good,
    input  wire logic aux_below_ref,
    input  wire logic aux_above_hyst,
    input  wire logic aux_monitor_strap,
    input  wire logic aux_fail_strap,
    input  wire logic force_backup_in,
    input  wire logic chip_sel_in,
    output logic      reset_out_n,
    output logic      battery_good_out,
    output logic      on_battery_out,
    output logic      batt_connect,
    output logic      batt_load_en,
    output logic      switched_supply_out,
    output logic      chip_sel_out,
    output logic      chip_sel_pullup,
    output logic      chip_sel_in_hiz,
    output logic      aux_fail_out,
    output logic      lowline_out
);

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    localparam int NS = 10;
    logic [NS-1:0] raw_in;
    logic [NS-1:0] sync1;
    logic [NS-1:0] sync2;
    assign raw_in = {above_reset_thr, above_lowline_thr, main_above_batt,
                     batt_above_good, aux_below_ref, aux_above_hyst,
                     aux_monitor_strap, aux_fail_strap, force_backup_in, chip_sel_in};
    // two flops per async flag; only sync2 is read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1 <= `BBS_SYNC_IDLE;
            sync2 <= `BBS_SYNC_IDLE;
        end else begin
            sync1 <= raw_in;
            sync2 <= sync1;
        end
    end
    logic s_vit, s_ll, s_mab, s_bgood, s_aux_lo, s_aux_hi, s_pfi_st, s_pfo_st, s_force, s_ce;
    assign {s_vit, s_ll, s_mab, s_bgood, s_aux_lo, s_aux_hi,
            s_pfi_st, s_pfo_st, s_force, s_ce} = sync2;

    // counter increment helper; wraps, does not saturate
    function automatic logic [`BBS_CNT_W-1:0] cnt_inc(input logic [`BBS_CNT_W-1:0] c);
        cnt_inc = c + `BBS_CNT_W'(1);
    endfunction : cnt_inc

    // ------------------------------------------------------------
    // reset delay, seal, source select, comparators
    // ------------------------------------------------------------
    logic [`BBS_CNT_W-1:0] por_cnt, next_por_cnt;
    logic                  rst_q, next_rst_q;
    logic                  seal, next_seal;
    logic                  forced, next_forced;
    logic                  on_batt, next_on_batt;
    logic                  aux_fail, next_aux_fail;
    logic                  seal_arm, next_seal_arm;

    // reset holds while main is low; delay timer restarts on every dip
    always_comb begin
        next_por_cnt  = por_cnt;
        next_rst_q    = rst_q;
        next_seal     = seal;
        next_seal_arm = seal_arm;
        next_forced   = forced;
        next_on_batt  = on_batt;
        next_aux_fail = aux_fail;
        if (!s_vit) begin
            next_por_cnt = '0;
            next_rst_q   = 1'b0;
        end else if (por_cnt >= POR_CYC - 32'd1) begin
            next_rst_q = 1'b1;
        end else begin
            next_por_cnt = cnt_inc(por_cnt);
        end
        // straps seen during the power-up delay arm the seal
        next_seal_arm = s_vit && !rst_q && s_pfi_st && !s_pfo_st;
        if (seal_arm && !s_vit)
            next_seal = 1'b1;
        else if (next_rst_q && !rst_q && !seal_arm)
            next_seal = 1'b0;
        // force latches until main drops below threshold
        if (!s_vit)
            next_forced = 1'b0;
        else if (s_force && !on_batt)
            next_forced = 1'b1;
        // forced, or below threshold and battery higher; either recovery returns
        // next_seal so the battery never connects in the cycle the seal sets
        if (next_seal)
            next_on_batt = 1'b0;
        else if (forced)
            next_on_batt = 1'b1;
        else if (!s_vit && !s_mab)
            next_on_batt = 1'b1;
        else if (s_vit || s_mab)
            next_on_batt = 1'b0;
        // hysteresis: fall below ref sets, rise above ref+hyst clears
        if (s_aux_lo)
            next_aux_fail = 1'b1;
        else if (s_aux_hi)
            next_aux_fail = 1'b0;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            por_cnt  <= '0;
            rst_q    <= 1'b0;
            seal     <= 1'b0;
            seal_arm <= 1'b0;
            forced   <= 1'b0;
            on_batt  <= 1'b0;
            aux_fail <= 1'b0;
        end else begin
            por_cnt  <= next_por_cnt;
            rst_q    <= next_rst_q;
            seal     <= next_seal;
            seal_arm <= next_seal_arm;
            forced   <= next_forced;
            on_batt  <= next_on_batt;
            aux_fail <= next_aux_fail;
        end
    end

    // ------------------------------------------------------------
    // battery measurement
    // ------------------------------------------------------------
    logic [`BBS_CNT_W-1:0] smp_cnt, next_smp_cnt;
    logic                  meas, next_meas;
    logic                  bgood, next_bgood;

    // period counter runs only with reset released and seal off
    always_comb begin
        next_smp_cnt = smp_cnt;
        next_meas    = meas;
        next_bgood   = bgood;
        if (!rst_q || seal) begin
            next_smp_cnt = '0;
            next_meas    = 1'b0;
        end else if (meas) begin
            if (smp_cnt >= `BBS_CNT_W'(`BBS_MEAS_CYC) - 32'd1) begin
                next_meas    = 1'b0;
                next_smp_cnt = '0;
                if (!s_bgood)
                    next_bgood = 1'b0;
            end else begin
                next_smp_cnt = cnt_inc(smp_cnt);
            end
        end else if (smp_cnt >= SAMPLE_CYC - 32'd1) begin
            next_meas    = 1'b1;
            next_smp_cnt = '0;
        end else begin
            next_smp_cnt = cnt_inc(smp_cnt);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            smp_cnt <= '0;
            meas    <= 1'b0;
            bgood   <= 1'b1;
        end else begin
            smp_cnt <= next_smp_cnt;
            meas    <= next_meas;
            bgood   <= next_bgood;
        end
    end

    // ------------------------------------------------------------
    // chip-select gate
    // ------------------------------------------------------------
    bbs_ce_t               ce_st, next_ce_st;
    logic [`BBS_CNT_W-1:0] ce_cnt, next_ce_cnt;
    logic                  ce_q, next_ce_q;

    // a pending write (input low) may finish for up to 15 us
    always_comb begin
        next_ce_st  = ce_st;
        next_ce_cnt = '0;
        next_ce_q   = 1'b1;
        case (ce_st)
            BBS_CE_PASS: begin
                next_ce_q = s_ce;
                if (!next_rst_q) begin
                    if (s_ce)
                        next_ce_st = BBS_CE_BLOCK;
                    else
                        next_ce_st = BBS_CE_DRAIN;
                    next_ce_q = s_ce;
                end
            end
            BBS_CE_DRAIN: begin
                next_ce_cnt = cnt_inc(ce_cnt);
                next_ce_q   = s_ce;
                if (s_ce || ce_cnt >= `BBS_CNT_W'(`BBS_CE_HOLD_CYC) - 32'd1) begin
                    next_ce_st = BBS_CE_BLOCK;
                    next_ce_q  = 1'b1;
                end
            end
            BBS_CE_BLOCK: begin
                if (rst_q)
                    next_ce_st = BBS_CE_PASS;
            end
            default: next_ce_st = BBS_CE_BLOCK;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ce_st  <= BBS_CE_BLOCK;
            ce_cnt <= '0;
            ce_q   <= 1'b1;
        end else begin
            ce_st  <= next_ce_st;
            ce_cnt <= next_ce_cnt;
            ce_q   <= next_ce_q;
        end
    end

    // outputs; lowline is a straight synchronised copy
    logic ll_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            ll_q <= 1'b0;
        else
            ll_q <= s_ll;
    end

    assign reset_out_n         = rst_q;
    assign battery_good_out    = bgood;
    assign on_battery_out      = on_batt;
    assign batt_connect        = on_batt && !seal;
    assign batt_load_en        = meas;
    assign switched_supply_out = on_batt;
    assign chip_sel_out        = ce_q;
    assign chip_sel_pullup     = (ce_st == BBS_CE_BLOCK);
    assign chip_sel_in_hiz     = (ce_st == BBS_CE_BLOCK);
    assign aux_fail_out        = !aux_fail;
    assign lowline_out         = ll_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_block_in_reset: assert property (!rst_q |-> ce_st != BBS_CE_PASS)
        else $error("chip select not isolated while blocked");
    chk_pullup_block: assert property (chip_sel_pullup |-> chip_sel_out)
        else $error("pulled up output not high");
    chk_seal_no_batt: assert property (seal |-> !on_battery_out)
        else $error("on battery during seal");
    chk_meas_gated: assert property (!rst_q |=> !batt_load_en)
        else $error("measuring under reset");
    chk_switch_back: assert property (s_vit && !forced && !seal |=> !on_batt)
        else $error("no return to main");
    chk_switch_over: assert property (!s_vit && !s_mab && !seal && !seal_arm |=> on_batt)
        else $error("no switchover");
    // the drain counter bounds the window; a range delay would be too long
    chk_drain_bound: assert property (ce_st == BBS_CE_DRAIN |-> ce_cnt < `BBS_CNT_W'(`BBS_CE_HOLD_CYC))
        else $error("drain too long");
    chk_aux_fail: assert property (s_aux_lo |=> !aux_fail_out)
        else $error("aux fail not low");
    chk_rst_hold: assert property (!s_vit |=> !reset_out_n)
        else $error("reset not held");

    cov_drain: cover property (ce_st == BBS_CE_DRAIN ##1 ce_st == BBS_CE_BLOCK);
    cov_meas: cover property ($fell(meas) && !bgood);
    cov_forced: cover property ($rose(forced));
    cov_seal: cover property ($fell(seal));

endmodule : bbs_supervisor

// [tb/bbs_host.sv]
// host processor model driving the ram chip-select line
// assumes one clk domain; the bench raises wr_req to hold a write
`timescale 1ns/10ps

module bbs_host (
    input  wire logic clk,
    input  wire logic wr_req,
    output logic      chip_sel_in
);
    // select moves just after the edge and stands while wr_req does
    initial chip_sel_in = 1'b1;
    always @(posedge clk) begin
        chip_sel_in <= #1 ~wr_req;
    end
endmodule : bbs_host

// [tb/tb.sv]
// self-checking bench for the supervisor control logic
// assumes short count parameters so the run stays a few thousand cycles
`timescale 1ns/10ps

module tb;
    import bbs_pkg::*;
    localparam logic [31:0] SAMP = 32'h0000_0032;
    localparam logic [31:0] POR  = 32'h0000_0014;
    logic clk, rst_n, thr, ll, mab, bgood, abr, ahy, mstrap, fstrap, force_b, wr_req;
    logic csi, rout_n, bgo, onb, bconn, bload, vsw, cso, pull, hiz, afo, llo;
    int   fails, n_compared, n;

    bbs_supervisor #(.SAMPLE_CYC(SAMP), .POR_CYC(POR)) i_dut (
        .clk(clk), .rst_n(rst_n), .above_reset_thr(thr), .above_lowline_thr(ll),
        .main_above_batt(mab), .batt_above_good(bgood), .aux_below_ref(abr),
        .aux_above_hyst(ahy), .aux_monitor_strap(mstrap), .aux_fail_strap(fstrap),
        .force_backup_in(force_b), .chip_sel_in(csi), .reset_out_n(rout_n),
        .battery_good_out(bgo), .on_battery_out(onb), .batt_connect(bconn),
        .batt_load_en(bload), .switched_supply_out(vsw), .chip_sel_out(cso),
        .chip_sel_pullup(pull), .chip_sel_in_hiz(hiz), .aux_fail_out(afo),
        .lowline_out(llo));
    bbs_host i_host (.clk(clk), .wr_req(wr_req), .chip_sel_in(csi));

    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : step
    task automatic chk(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_n(input int got, input int exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_n
    // early check guards against a delay counter that is too short
    task automatic power_up;
        thr = 1'b1;
        step(15);
        chk(rout_n, 1'b0);
        for (n = 0; n < 20 && rout_n !== 1'b1; n++) step(1);
        chk(rout_n, 1'b1);
        step(2);
    endtask : power_up
    task automatic conclude;
        $display("compared=%0d fails=%0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_reset;
        step(int'(SAMP) + 60);
        chk(rout_n, 1'b0);
        chk(bload, 1'b0);
        chk(hiz, 1'b1);
        chk(pull, 1'b1);
    endtask : t_reset
    // strapped main pulse shorter than the reset delay arms the seal
    task automatic t_seal;
        mstrap = 1'b1;
        fstrap = 1'b0;
        thr = 1'b1;
        step(10);
        chk(rout_n, 1'b0);
        mstrap = 1'b0;
        fstrap = 1'b1;
        thr = 1'b0;
        mab = 1'b0;
        step(8);
        chk(pull, 1'b1);
        chk(onb, 1'b0);
        chk(bconn, 1'b0);
        mab = 1'b1;
        power_up();
        thr = 1'b0;
        mab = 1'b0;
        step(8);
        chk(onb, 1'b1);
        chk(vsw, 1'b1);
        chk(bconn, 1'b1);
        chk(hiz, 1'b1);
        mab = 1'b1;
        step(6);
        chk(onb, 1'b0);
        chk(vsw, 1'b0);
        power_up();
        mab = 1'b0;
        step(6);
        chk(onb, 1'b0);
        mab = 1'b1;
    endtask : t_seal
    task automatic t_gate_aux;
        wr_req = 1'b1;
        step(5);
        chk(cso, 1'b0);
        chk(pull, 1'b0);
        wr_req = 1'b0;
        step(5);
        chk(cso, 1'b1);
        abr = 1'b1;
        ahy = 1'b0;
        step(6);
        chk(afo, 1'b0);
        abr = 1'b0;
        step(6);
        chk(afo, 1'b0);
        ahy = 1'b1;
        step(6);
        chk(afo, 1'b1);
        chk(llo, 1'b1);
        ll = 1'b0;
        step(6);
        chk(llo, 1'b0);
        ll = 1'b1;
    endtask : t_gate_aux
    // low cell: window length counted, status falls after it
    task automatic t_batt;
        bgood = 1'b0;
        for (n = 0; n < int'(SAMP) + 100 && bload !== 1'b1; n++) step(1);
        chk(bload, 1'b1);
        chk(bgo, 1'b1);
        n = 0;
        while (bload === 1'b1 && n < 3000) begin
            step(1);
            n++;
        end
        chk_n(n, 2500);
        step(6);
        chk(bgo, 1'b0);
    endtask : t_batt
    // write held across the supply drop passes through, then times out
    task automatic t_drain;
        wr_req = 1'b1;
        step(4);
        thr = 1'b0;
        step(6);
        chk(rout_n, 1'b0);
        step(1300);
        chk(cso, 1'b0);
        step(300);
        chk(pull, 1'b1);
        chk(cso, 1'b1);
        wr_req = 1'b0;
    endtask : t_drain
    task automatic t_force;
        power_up();
        force_b = 1'b1;
        step(6);
        chk(onb, 1'b1);
        force_b = 1'b0;
        step(6);
        chk(onb, 1'b1);
    endtask : t_force

    // ---------------------------------------------------------------
    // clock, main sequence and watchdog
    // ---------------------------------------------------------------
    always #5 clk = ~clk;
    initial begin
        {clk, rst_n, thr, ll, bgood, abr, mstrap, force_b, wr_req} = '0;
        {mab, ahy, fstrap} = 3'b111;
        fails = 0;
        n_compared = 0;
        step(8);
        rst_n = 1'b1;
        ll = 1'b1;
        bgood = 1'b1;
        t_reset();
        t_seal();
        t_gate_aux();
        t_batt();
        t_drain();
        t_force();
        conclude();
    end
    // whole run needs roughly 4400 cycles
    initial begin
        #400us;
        fails++;
        conclude();
    end
endmodule : tb
